// [rtl/pwm_trigger_sync_routing.v]
// Glue routing sync, faults, triggers and interrupts around nine PWM modules
//
// Contract
// - First module sync out is stretched to 8 clock cycles toward pin mux.
// - Nine trigger A outputs ORed, stretched to 32 cycles, one merged output.
// - Nine trigger B outputs ORed, stretched to 32 cycles, one merged output.
// - Fifteen fault lines: twelve pin faults, RAM error, expander error, one spare held low.
// - Six zone inputs from pin faults 1-3, encoder, clock loss, debug halt.
// - Sync sources are pin fault line one and the timebase clock sync bit.
// - All eighteen individual triggers also go unmerged to the ADC side.
// - Each module drives own event and shutdown interrupt to the expander.
// - Modules one to eight have fine edge placement; module nine standard.
`include "pwm_glue_defs.vh"

module pwm_trigger_sync_routing
(
	// Clock and reset
	input  wire                          mclk_i,
	input  wire                          nrst_i,

	// Pin fault lines from the pin fault multiplexer (asynchronous)
	input  wire [`FAULT_PIN_COUNT-1:0]   mux_pin_fault_line_i,

	// On-chip fault and status sources (same clock)
	input  wire                          ram_double_bit_error_i,
	input  wire                          interrupt_expander_error_i,
	input  wire                          encoder_error_i,
	input  wire                          clock_loss_flag_i,
	input  wire                          debug_halt_i,
	input  wire                          timebase_clock_sync_i,

	// Outputs of the nine PWM modules
	input  wire                          first_module_sync_out_i,
	input  wire [`PWM_MODULE_COUNT-1:0]  conv_trigger_a_i,
	input  wire [`PWM_MODULE_COUNT-1:0]  conv_trigger_b_i,
	input  wire [`PWM_MODULE_COUNT-1:0]  pwm_event_irq_i,
	input  wire [`PWM_MODULE_COUNT-1:0]  pwm_shutdown_irq_i,

	// Inputs delivered to every PWM module
	output wire                          external_sync_in_o,
	output wire                          timebase_clock_sync_o,
	output wire [`FAULT_BUS_WIDTH-1:0]   fault_lines_o,
	output wire [`ZONE_BUS_WIDTH-1:0]    shutdown_zone_input_o,
	output wire [`PWM_MODULE_COUNT-1:0]  fine_edge_pwm_o,

	// Toward the pin fault multiplexer
	output wire                          stretched_sync_out_o,
	output wire                          merged_conv_trigger_a_out_o,
	output wire                          merged_conv_trigger_b_out_o,

	// Toward the analog subsystem
	output wire [`PWM_MODULE_COUNT-1:0]  adc_trigger_a_o,
	output wire [`PWM_MODULE_COUNT-1:0]  adc_trigger_b_o,

	// Toward the interrupt expander
	output wire [`PWM_MODULE_COUNT-1:0]  event_irq_o,
	output wire [`PWM_MODULE_COUNT-1:0]  shutdown_irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// OR reduce of one trigger group, used for both A and B
	function any_high;
		input [`PWM_MODULE_COUNT-1:0] vec;
		begin
			any_high = |vec;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser

	reg  [`FAULT_PIN_COUNT-1:0]  pin_meta_reg;
	reg  [`FAULT_PIN_COUNT-1:0]  pin_sync_reg;

	// Pin faults come from another domain; first stage feeds only the second
	always @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_meta_reg <= {`FAULT_PIN_COUNT{1'b0}};
			pin_sync_reg <= {`FAULT_PIN_COUNT{1'b0}};
		end
		else
		begin
			pin_meta_reg <= mux_pin_fault_line_i;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault, zone and sync routing

	reg  [`FAULT_BUS_WIDTH-1:0]  fault_reg;
	reg  [`FAULT_BUS_WIDTH-1:0]  fault_next;
	reg  [`ZONE_BUS_WIDTH-1:0]   zone_reg;
	reg  [`ZONE_BUS_WIDTH-1:0]   zone_next;
	reg                          ext_sync_reg;
	reg                          tb_sync_reg;

	// General fault bus; the spare line is held inactive
	always @*
	begin
		fault_next = {`FAULT_BUS_WIDTH{1'b0}};
		fault_next[`FAULT_PIN_MSB:`FAULT_PIN_LSB] = pin_sync_reg;
		fault_next[`FAULT_RAM_DBE_BIT] = ram_double_bit_error_i;
		fault_next[`FAULT_IRQ_EXP_BIT] = interrupt_expander_error_i;
	end

	// Shutdown-zone bus
	always @*
	begin
		zone_next = {`ZONE_BUS_WIDTH{1'b0}};
		zone_next[`ZONE_PIN_MSB:`ZONE_PIN_LSB] = pin_sync_reg[`ZONE_PIN_MSB:`ZONE_PIN_LSB];
		zone_next[`ZONE_ENCODER_BIT] = encoder_error_i;
		zone_next[`ZONE_CLOCK_LOSS_BIT] = clock_loss_flag_i;
		zone_next[`ZONE_DEBUG_HALT_BIT] = debug_halt_i;
	end

	// Registered so each module sees the same edge of every source
	always @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			fault_reg    <= {`FAULT_BUS_WIDTH{1'b0}};
			zone_reg     <= {`ZONE_BUS_WIDTH{1'b0}};
			ext_sync_reg <= 1'b0;
			tb_sync_reg  <= 1'b0;
		end
		else
		begin
			fault_reg    <= fault_next;
			zone_reg     <= zone_next;
			ext_sync_reg <= pin_sync_reg[`SYNC_PIN_BIT];
			tb_sync_reg  <= timebase_clock_sync_i;
		end
	end

	assign fault_lines_o         = fault_reg;
	assign shutdown_zone_input_o = zone_reg;
	assign external_sync_in_o    = ext_sync_reg;
	assign timebase_clock_sync_o = tb_sync_reg;

	////////////////////////////////////////////////////////////////////////////
	// Resolution capability

	reg  [`PWM_MODULE_COUNT-1:0] fine_edge_reg;

	// Only modules one to eight carry the fine edge stage
	always @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			fine_edge_reg <= `PWM_FINE_EDGE_MASK;
		else
			fine_edge_reg <= `PWM_FINE_EDGE_MASK;
	end

	assign fine_edge_pwm_o = fine_edge_reg;

	////////////////////////////////////////////////////////////////////////////
	// Per-module fan-out to the ADC side and the interrupt expander

	reg  [`PWM_MODULE_COUNT-1:0] adc_a_reg;
	reg  [`PWM_MODULE_COUNT-1:0] adc_b_reg;
	reg  [`PWM_MODULE_COUNT-1:0] evt_irq_reg;
	reg  [`PWM_MODULE_COUNT-1:0] sd_irq_reg;

	genvar m;
	generate
		for (m = 0; m < `PWM_MODULE_COUNT; m = m + 1)
		begin : g_fanout
			// One flop per line keeps every module's path the same length
			always @(posedge mclk_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					adc_a_reg[m]   <= 1'b0;
					adc_b_reg[m]   <= 1'b0;
					evt_irq_reg[m] <= 1'b0;
					sd_irq_reg[m]  <= 1'b0;
				end
				else
				begin
					adc_a_reg[m]   <= conv_trigger_a_i[m];
					adc_b_reg[m]   <= conv_trigger_b_i[m];
					evt_irq_reg[m] <= pwm_event_irq_i[m];
					sd_irq_reg[m]  <= pwm_shutdown_irq_i[m];
				end
			end
		end
	endgenerate

	assign adc_trigger_a_o = adc_a_reg;
	assign adc_trigger_b_o = adc_b_reg;
	assign event_irq_o     = evt_irq_reg;
	assign shutdown_irq_o  = sd_irq_reg;

	////////////////////////////////////////////////////////////////////////////
	// Stretchers toward the pin multiplexer

	wire                         trig_a_any;
	wire                         trig_b_any;

	// Merge is combinational; the stretcher supplies the output flop
	assign trig_a_any = any_high(conv_trigger_a_i);
	assign trig_b_any = any_high(conv_trigger_b_i);

	// Sync out is short at the source; widen so the pin can see it
	pulse_stretch
	#(
		.LEN (`SYNC_STRETCH_CYCLES)
	)
	u_sync_stretch
	(
		.mclk_i      (mclk_i),
		.nrst_i      (nrst_i),
		.pulse_i     (first_module_sync_out_i),
		.stretched_o (stretched_sync_out_o)
	);

	// Merged trigger A
	pulse_stretch
	#(
		.LEN (`TRIG_STRETCH_CYCLES)
	)
	u_trig_a_stretch
	(
		.mclk_i      (mclk_i),
		.nrst_i      (nrst_i),
		.pulse_i     (trig_a_any),
		.stretched_o (merged_conv_trigger_a_out_o)
	);

	// Merged trigger B
	pulse_stretch
	#(
		.LEN (`TRIG_STRETCH_CYCLES)
	)
	u_trig_b_stretch
	(
		.mclk_i      (mclk_i),
		.nrst_i      (nrst_i),
		.pulse_i     (trig_b_any),
		.stretched_o (merged_conv_trigger_b_out_o)
	);

endmodule // pwm_trigger_sync_routing

// [rtl/pwm_glue_defs.vh]
// Constants for the PWM trigger, sync and fault routing glue
`ifndef PWM_GLUE_DEFS_VH
`define PWM_GLUE_DEFS_VH

// Module population
`define PWM_MODULE_COUNT      9
`define PWM_FINE_EDGE_MASK    9'h0ff

// Pulse stretch lengths in high-speed peripheral clock cycles
`define SYNC_STRETCH_CYCLES   6'h08
`define TRIG_STRETCH_CYCLES   6'h20
`define STRETCH_CNT_WIDTH     6

// General fault bus layout
`define FAULT_BUS_WIDTH       15
`define FAULT_PIN_COUNT       12
`define FAULT_PIN_LSB         0
`define FAULT_PIN_MSB         11
`define FAULT_RAM_DBE_BIT     12
`define FAULT_IRQ_EXP_BIT     13
`define FAULT_SPARE_BIT       14

// Shutdown-zone bus layout
`define ZONE_BUS_WIDTH        6
`define ZONE_PIN_LSB          0
`define ZONE_PIN_MSB          2
`define ZONE_ENCODER_BIT      3
`define ZONE_CLOCK_LOSS_BIT   4
`define ZONE_DEBUG_HALT_BIT   5

// Pin used as the external sync source
`define SYNC_PIN_BIT          0

`endif

// [rtl/pulse_stretch.v]
// Retriggerable pulse stretcher with a registered output
`include "pwm_glue_defs.vh"

module pulse_stretch
#(
	parameter [`STRETCH_CNT_WIDTH-1:0] LEN = `SYNC_STRETCH_CYCLES
)
(
	// Clock and reset
	input  wire mclk_i,
	input  wire nrst_i,
	// Pulse in and stretched pulse out
	input  wire pulse_i,
	output wire stretched_o
);

	reg  [`STRETCH_CNT_WIDTH-1:0] cnt_reg;
	reg  [`STRETCH_CNT_WIDTH-1:0] cnt_next;
	reg                           out_reg;

	// Any high input cycle reloads, so output runs LEN cycles past the last one
	always @*
	begin
		if (pulse_i)
			cnt_next = LEN;
		else if (cnt_reg != {`STRETCH_CNT_WIDTH{1'b0}})
			cnt_next = cnt_reg - {{(`STRETCH_CNT_WIDTH-1){1'b0}}, 1'b1};
		else
			cnt_next = cnt_reg;
	end

	// Output taken from next count so it rises one edge after the input
	always @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cnt_reg <= {`STRETCH_CNT_WIDTH{1'b0}};
			out_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			out_reg <= (cnt_next != {`STRETCH_CNT_WIDTH{1'b0}});
		end
	end

	assign stretched_o = out_reg;

endmodule // pulse_stretch

// [tb/pwm_glue_sva.sv]
// Checker for the PWM trigger, sync and fault routing glue
module pwm_glue_sva (
	// Clock, reset, single inputs and input vectors
	input wire logic mclk_i, nrst_i, ram_double_bit_error_i, interrupt_expander_error_i,
	input wire logic encoder_error_i, clock_loss_flag_i, debug_halt_i, timebase_clock_sync_i,
	input wire logic first_module_sync_out_i,
	input wire logic [11:0] mux_pin_fault_line_i,
	input wire logic [8:0] conv_trigger_a_i, conv_trigger_b_i, pwm_event_irq_i, pwm_shutdown_irq_i,
	// Outputs watched
	input wire logic external_sync_in_o, timebase_clock_sync_o, stretched_sync_out_o,
	input wire logic merged_conv_trigger_a_out_o, merged_conv_trigger_b_out_o,
	input wire logic [14:0] fault_lines_o,
	input wire logic [5:0] shutdown_zone_input_o,
	input wire logic [8:0] fine_edge_pwm_o, adc_trigger_a_o, adc_trigger_b_o, event_irq_o, shutdown_irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	logic [5:0] age_a_reg, age_b_reg;
	//////////////////////
	// Cycles since last trigger; saturates so a quiet line never wraps into range
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			{age_a_reg, age_b_reg} <= 12'hfff;
		else
		begin
			age_a_reg <= (|conv_trigger_a_i) ? 6'h00 : age_a_reg + {5'h00, age_a_reg != 6'h3f};
			age_b_reg <= (|conv_trigger_b_i) ? 6'h00 : age_b_reg + {5'h00, age_b_reg != 6'h3f};
		end
	end
	sequence sync_hit; first_module_sync_out_i; endsequence
	sequence sync_quiet; !first_module_sync_out_i [*8]; endsequence
	sequence up_4; nrst_i [*4]; endsequence
	//////////////////////
	// Output is registered, so it shows from the edge after the pulse is sampled
	sync_hold_a: assert property (sync_hit |-> ##1 stretched_sync_out_o [*8])
		else $error("sync pulse short");
	sync_end_a: assert property (sync_hit ##1 sync_quiet |-> ##1 !stretched_sync_out_o)
		else $error("sync pulse long");
	// Age 0 to 31 covers exactly the 32 high cycles after the last trigger
	trig_a_len_a: assert property (age_a_reg != 6'h00 |-> merged_conv_trigger_a_out_o == (age_a_reg < 6'h20))
		else $error("trigger a length");
	trig_b_len_a: assert property (age_b_reg != 6'h00 |-> merged_conv_trigger_b_out_o == (age_b_reg < 6'h20))
		else $error("trigger b length");
	fault_route_a: assert property (up_4 |-> fault_lines_o == {1'b0, $past(interrupt_expander_error_i),
		$past(ram_double_bit_error_i), $past(mux_pin_fault_line_i, 3)}) else $error("fault lines");
	zone_route_a: assert property (up_4 |-> shutdown_zone_input_o == {$past(debug_halt_i),
		$past(clock_loss_flag_i), $past(encoder_error_i), fault_lines_o[2:0]}) else $error("zone inputs");
	sync_route_a: assert property (up_4 |-> external_sync_in_o == fault_lines_o[0]
		&& timebase_clock_sync_o == $past(timebase_clock_sync_i)) else $error("sync sources");
	adc_route_a: assert property (up_4 |-> adc_trigger_a_o == $past(conv_trigger_a_i)
		&& adc_trigger_b_o == $past(conv_trigger_b_i)) else $error("adc triggers");
	irq_route_a: assert property (up_4 |-> event_irq_o == $past(pwm_event_irq_i)
		&& shutdown_irq_o == $past(pwm_shutdown_irq_i)) else $error("interrupts");
	fine_edge_a: assert property (fine_edge_pwm_o == 9'h0ff) else $error("fine edge mask");
endmodule // pwm_glue_sva
bind pwm_trigger_sync_routing pwm_glue_sva pwm_glue_sva_inst (.*);

// [tb/pin_mux_model.sv]
// Pin fault multiplexer model driving the asynchronous pin fault lines
module pin_mux_model (
	input  wire logic [11:0] pattern_i,
	output logic      [11:0] pin_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pins settle mid-cycle, so the design's synchroniser is really exercised
	initial pin_o = 12'h000;
	always @(pattern_i) pin_o <= #7 pattern_i;
endmodule // pin_mux_model

// [tb/pwm_trigger_sync_routing_tb.sv]
// Testbench for the PWM trigger, sync and fault routing glue
module pwm_trigger_sync_routing_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk_i, nrst_i, ram_double_bit_error_i, interrupt_expander_error_i, encoder_error_i;
	logic clock_loss_flag_i, debug_halt_i, timebase_clock_sync_i, first_module_sync_out_i;
	logic [8:0] conv_trigger_a_i, conv_trigger_b_i, pwm_event_irq_i, pwm_shutdown_irq_i;
	logic [11:0] pin_pattern;
	wire [11:0] mux_pin_fault_line_i;
	wire external_sync_in_o, timebase_clock_sync_o, stretched_sync_out_o;
	wire merged_conv_trigger_a_out_o, merged_conv_trigger_b_out_o;
	wire [14:0] fault_lines_o;
	wire [5:0] shutdown_zone_input_o;
	wire [8:0] fine_edge_pwm_o, adc_trigger_a_o, adc_trigger_b_o, event_irq_o, shutdown_irq_o;
	int error_cnt, tests_run, n;
	// Row: pins, misc inputs, triggers a/b, irqs, expected fault lines and zones
	logic [74:0] rows [3] = '{{12'h001, 6'h2a, 9'h101, 9'h0fe, 9'h155, 9'h0aa, 15'h1001, 6'h29},
		{12'hffe, 6'h15, 9'h0fe, 9'h101, 9'h0aa, 9'h155, 15'h2ffe, 6'h16},
		{12'h804, 6'h3f, 9'h1ff, 9'h000, 9'h100, 9'h001, 15'h3804, 6'h3c}};
	// Stretch table: output select, pattern, hold cycles, retrigger cycle, high cycles
	int st [6][5] = '{'{0, 1, 1, -1, 8}, '{0, 1, 1, 5, 13}, '{1, 'h100, 1, -1, 32},
		'{1, 'h011, 3, -1, 34}, '{2, 1, 1, -1, 32}, '{2, 'h0a0, 1, 20, 52}};
	pwm_trigger_sync_routing pwm_trigger_sync_routing_inst (.*);
	pin_mux_model pin_mux_model_inst (.pattern_i(pin_pattern), .pin_o(mux_pin_fault_line_i));
	//////////////////////
	task chk(input logic [17:0] got, input logic [17:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Pulses one source and counts high cycles of its stretched output
	task stretch(input int sel, input int v, input int k, input int g, output int cnt);
		logic [8:0] d;
		cnt = 0;
		for (int i = 0; i < 60; i++)
		begin
			@(posedge mclk_i);
			#2;
			d = (i < k || i == g) ? v[8:0] : 9'h000;
			first_module_sync_out_i = (sel == 0) & d[0];
			conv_trigger_a_i = (sel == 1) ? d : 9'h000;
			conv_trigger_b_i = (sel == 2) ? d : 9'h000;
			cnt += (sel == 0) ? stretched_sync_out_o : (sel == 1) ? merged_conv_trigger_a_out_o
				: merged_conv_trigger_b_out_o;
		end
	endtask
	//////////////////////
	// Free-running 40 MHz clock
	initial
	begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// Watchdog; the whole run needs well under a thousand cycles
	initial
	begin
		#100us;
		error_cnt++;
		stop_test;
	end
	// Reset with busy inputs, routing rows, stretch table, reset mid-stretch
	initial
	begin
		{nrst_i, ram_double_bit_error_i, interrupt_expander_error_i, encoder_error_i} = 4'h0;
		{clock_loss_flag_i, debug_halt_i, timebase_clock_sync_i, first_module_sync_out_i} = 4'hf;
		{conv_trigger_a_i, conv_trigger_b_i, pwm_event_irq_i, pwm_shutdown_irq_i} = {4{9'h1ff}};
		{pin_pattern, error_cnt, tests_run} = {12'hfff, 64'h0};
		repeat (15) @(posedge mclk_i);
		#2;
		chk({fault_lines_o, merged_conv_trigger_a_out_o, stretched_sync_out_o, external_sync_in_o}, 18'h0);
		chk({adc_trigger_a_o, event_irq_o}, 18'h0);
		chk(fine_edge_pwm_o, 18'h0ff);
		@(posedge mclk_i);
		#2;
		nrst_i = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			{pin_pattern, ram_double_bit_error_i, interrupt_expander_error_i, encoder_error_i, clock_loss_flag_i,
				debug_halt_i, timebase_clock_sync_i, conv_trigger_a_i, conv_trigger_b_i, pwm_event_irq_i,
				pwm_shutdown_irq_i} = rows[i][74:21];
			repeat (4) @(posedge mclk_i);
			#2;
			chk(fault_lines_o, rows[i][20:6]);
			chk(shutdown_zone_input_o, rows[i][5:0]);
			chk({external_sync_in_o, timebase_clock_sync_o}, {rows[i][63], rows[i][57]});
			chk({adc_trigger_a_o, adc_trigger_b_o}, rows[i][56:39]);
			chk({event_irq_o, shutdown_irq_o}, rows[i][38:21]);
			chk(fine_edge_pwm_o, 18'h0ff);
		end
		{first_module_sync_out_i, conv_trigger_a_i, conv_trigger_b_i} = 19'h0;
		repeat (40) @(posedge mclk_i);
		for (int j = 0; j < 6; j++)
		begin
			stretch(st[j][0], st[j][1], st[j][2], st[j][3], n);
			chk(18'(n), 18'(st[j][4]));
		end
		// Let an edge pass so the trigger is not driven twice in one step
		@(posedge mclk_i);
		#2;
		conv_trigger_a_i = 9'h004;
		@(posedge mclk_i);
		#2;
		conv_trigger_a_i = 9'h000;
		repeat (3) @(posedge mclk_i);
		#2;
		chk(merged_conv_trigger_a_out_o, 18'h1);
		nrst_i = 1'b0;
		#1;
		chk({merged_conv_trigger_a_out_o, fine_edge_pwm_o}, 18'h0ff);
		repeat (2) @(posedge mclk_i);
		#2;
		nrst_i = 1'b1;
		repeat (5) @(posedge mclk_i);
		#2;
		chk(merged_conv_trigger_a_out_o, 18'h0);
		stop_test;
	end
endmodule // pwm_trigger_sync_routing_tb
